// >>> src/flash_protect_pkg.sv
package flash_protect_pkg;

    // serial command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] OP_READ_STATUS    = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
    localparam logic [7:0] OP_READ_FLAGS     = 8'h70;
    localparam logic [7:0] OP_CLEAR_FLAGS    = 8'h50;
    localparam logic [7:0] OP_PROGRAM        = 8'h12;
    localparam logic [7:0] OP_SECTOR_ERASE   = 8'hdc;
    localparam logic [7:0] OP_SUB4_ERASE     = 8'h21;
    localparam logic [7:0] OP_SUB32_ERASE    = 8'h5c;
    localparam logic [7:0] OP_BULK_ERASE     = 8'hc7;

    // frame lengths in serial bits
    localparam int          CNT_W       = 6;
    localparam logic [5:0]  CMD_BITS    = 6'h08;
    localparam logic [5:0]  DATA_BITS   = 6'h10;
    localparam logic [5:0]  ADDR_BITS   = 6'h28;
    localparam logic [5:0]  PROG_BITS   = 6'h30;
    localparam logic [5:0]  BITS_MAX    = 6'h3f;

    // status register layout
    localparam int          SR_WIDTH    = 8;
    localparam int          SR_WDIS_BIT = 7;
    localparam int          SR_LVL3_BIT = 6;
    localparam int          SR_TB_BIT   = 5;
    localparam int          SR_LVL_HI   = 4;
    localparam int          SR_LVL_LO   = 2;
    localparam int          SR_WEL_BIT  = 1;
    localparam int          SR_BUSY_BIT = 0;
    localparam logic [7:0]  SR_RESET    = 8'h00;

    // flag status register layout
    localparam int          FL_READY_BIT = 7;
    localparam int          FL_ERASE_BIT = 4 + 1;
    localparam int          FL_PROG_BIT  = 4;
    localparam int          FL_PROT_BIT  = 1;
    localparam int          FL_ADDR4_BIT = 0;

    // array organisation
    localparam int          ADDR_W      = 25;
    localparam int          SECTOR_W    = 9;
    localparam int          SECTOR_LSB  = 16;
    localparam int          LEVEL_W     = 4;
    localparam logic [3:0]  LEVEL_NONE  = 4'h0;
    localparam logic [3:0]  LEVEL_FULL  = 4'ha;

    // timing
    localparam int          MCLK_PERIOD_NS = 40;

    typedef enum logic [1:0] {
        ARR_PROGRAM,
        ARR_ERASE_SUB,
        ARR_ERASE_SECTOR,
        ARR_ERASE_BULK
    } array_op_t;

endpackage

// >>> src/flash_status_block_protect.sv
// Behaviour
// [RQ1] read-status returns the eight status bits; write-status stores them (code stores bits 7:2 only)
// [RQ2] bit 7 set with write-protect low makes write-status ignored
// [RQ3] only raising write-protect releases the hardware lock
// [RQ4] bit 7 nonvolatile, zero by default, disables status writes
// [RQ5] bit 5 anchors protected range: zero top, one bottom
// [RQ6] protect level at bits 6,4:2; nonzero refuses program/erase in range
// [RQ7] write-enable latch cleared at reset, required for any write
// [RQ8] bit 0 busy during status write, program or erase
// [RQ9] whole-array erase only when protect level is zero
// [RQ10] busy bit is the inverse of the flag ready bit
// [RQ11] protect level zero protects nothing
// [RQ12] top: level n protects sectors 511 down to 512-2^(n-1)
// [RQ13] bottom: level n protects sectors 0 up to 2^(n-1)-1
// [RQ14] levels 10 to 15 protect the whole array
// [RQ15] 32MB array, 512 sectors of 64KB, sector from upper address bits
// [RQ16] protected program/erase leaves array alone and sets protection flag
// [RQ17] host must always drive write-protect, it has no pull-up
// [RQ18] refused status write leaves every status bit unchanged
`timescale 1ns/100ps
`default_nettype none
module flash_status_block_protect
    import flash_protect_pkg::*;
#(
    parameter int WRSR_TIME_NS  = 2000,
    parameter int PROG_TIME_NS  = 8000,
    parameter int ERASE_TIME_NS = 40000,
    parameter int BULK_TIME_NS  = 160000
) (
    input  wire logic                            mclk,
    input  wire logic                            sys_rst,
    input  wire logic                            link_sclk,
    input  wire logic                            link_cs_n,
    input  wire logic                            link_mosi,
    input  wire logic                            wp_n,
    output var  logic                            link_miso,
    output var  logic                            link_miso_oe,
    output var  logic [flash_protect_pkg::SR_WIDTH-1:0]
                                                 status_protect_register,
    output var  logic                            array_strobe,
    output var  flash_protect_pkg::array_op_t    array_op,
    output var  logic [flash_protect_pkg::ADDR_W-1:0] array_addr
);
    import flash_protect_pkg::*;

    localparam int WRSR_CYC  = (WRSR_TIME_NS + MCLK_PERIOD_NS - 1)
                               / MCLK_PERIOD_NS;
    localparam int PROG_CYC  = (PROG_TIME_NS + MCLK_PERIOD_NS - 1)
                               / MCLK_PERIOD_NS;
    localparam int ERASE_CYC = (ERASE_TIME_NS + MCLK_PERIOD_NS - 1)
                               / MCLK_PERIOD_NS;
    localparam int BULK_CYC  = (BULK_TIME_NS + MCLK_PERIOD_NS - 1)
                               / MCLK_PERIOD_NS;
    localparam int TMR_W     = 24;

    if (WRSR_CYC < 1 || PROG_CYC < 1 || ERASE_CYC < 1 || BULK_CYC < 1 ||
        BULK_CYC >= (1 << TMR_W)) begin : g_check
        $error("flash_status_block_protect: busy time out of range");
    end

    // ---------------- link domain (serial clock) ----------------
    logic [CNT_W-1:0]  bit_cnt;
    logic [CNT_W-1:0]  frame_bits;
    logic [31:0]       shift_in;
    logic [7:0]        cmd_byte;
    logic [7:0]        data_byte;
    logic [31:0]       addr_word;
    logic              read_active;
    logic [7:0]        read_byte;
    logic [2:0]        out_ptr;
    logic [7:0]        status_snap;
    logic [7:0]        flag_snap;

    wire  [31:0]       next_shift;
    wire  [CNT_W-1:0]  next_bits;
    wire               is_read_cmd;

    assign next_shift  = {shift_in[30:0], link_mosi};
    assign next_bits   = (bit_cnt == BITS_MAX) ? bit_cnt
                                               : bit_cnt + CNT_W'(1);
    assign is_read_cmd = (next_shift[7:0] == OP_READ_STATUS) ||
                         (next_shift[7:0] == OP_READ_FLAGS);

    // bit counter restarts whenever the frame is deselected
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= next_bits;
        end
    end

    // frame fields stay put after deselect until the next frame
    always_ff @(posedge link_sclk) begin
        shift_in   <= next_shift;
        frame_bits <= next_bits;
        if (next_bits == CMD_BITS) begin
            cmd_byte <= next_shift[7:0];
        end
        if (next_bits == DATA_BITS) begin
            data_byte <= next_shift[7:0];
        end
        if (next_bits == ADDR_BITS) begin
            addr_word <= next_shift;
        end
    end

    // status snapshot is frozen in the core domain while selected
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            read_active <= 1'b0;
            read_byte   <= SR_RESET;
        end else if (next_bits == CMD_BITS && is_read_cmd) begin
            read_active <= 1'b1;                                   // RQ1
            read_byte   <= (next_shift[7:0] == OP_READ_STATUS)
                           ? status_snap : flag_snap;
        end
    end

    // data leaves on the falling edge, msb first, repeating
    always_ff @(negedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            link_miso    <= 1'b0;
            link_miso_oe <= 1'b0;
            out_ptr      <= 3'h7;
        end else begin
            link_miso_oe <= read_active;
            if (read_active) begin
                link_miso <= read_byte[out_ptr];                   // RQ1
                out_ptr   <= out_ptr - 3'h1;
            end
        end
    end

    // ---------------- core domain (mclk) ----------------
    logic [2:0]          cs_meta;
    logic [2:0]          wp_meta;
    logic                cs_stable;
    logic                cs_stable_q;
    logic                wp_stable;
    logic                wdis;
    logic                bottom;
    logic [LEVEL_W-1:0]  level;
    logic                wel;
    logic                busy;
    logic [TMR_W-1:0]    busy_tmr;
    logic                prot_err;
    logic                prog_err;
    logic                erase_err;

    protect_range_if #(.SECTOR_W(SECTOR_W), .LEVEL_W(LEVEL_W)) prot ();

    protect_range_decode #(
        .SECTOR_W (SECTOR_W),
        .LEVEL_W  (LEVEL_W)
    ) u_decode (
        .prot (prot.decoder)
    );

    assign prot.level  = level;
    assign prot.bottom = bottom;
    assign prot.sector = addr_word[SECTOR_LSB +: SECTOR_W];        // RQ15

    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        cs_meta <= {cs_meta[1:0], link_cs_n};
        wp_meta <= {wp_meta[1:0], wp_n};                           // RQ17
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cs_stable   <= 1'b1;
            cs_stable_q <= 1'b1;
            wp_stable   <= 1'b1;
        end else begin
            if (cs_meta[1] == cs_meta[2]) begin
                cs_stable <= cs_meta[2];
            end
            if (wp_meta[1] == wp_meta[2]) begin
                wp_stable <= wp_meta[2];                           // RQ3
            end
            cs_stable_q <= cs_stable;
        end
    end

    wire [7:0] sr_value;
    wire [7:0] fl_value;
    wire       frame_done;
    wire       locked;
    wire       write_ok;
    wire       is_wren;
    wire       is_wrdi;
    wire       is_wrsr;
    wire       is_clfl;
    wire       is_prog;
    wire       is_erase;
    wire       is_bulk;
    wire       erase_cmd;
    wire       protected_hit;
    wire       bulk_refused;
    wire       refuse;
    wire       start;
    wire       any_err_cmd;
    array_op_t next_op;
    wire [TMR_W-1:0] next_tmr;

    assign sr_value[SR_WDIS_BIT]          = wdis;                  // RQ4
    assign sr_value[SR_LVL3_BIT]          = level[3];              // RQ6
    assign sr_value[SR_TB_BIT]            = bottom;                // RQ5
    assign sr_value[SR_LVL_HI:SR_LVL_LO]  = level[2:0];
    assign sr_value[SR_WEL_BIT]           = wel;                   // RQ7
    assign sr_value[SR_BUSY_BIT]          = busy;                  // RQ8

    assign fl_value[FL_READY_BIT]   = ~busy;                       // RQ10
    assign fl_value[6]              = 1'b0;
    assign fl_value[FL_ERASE_BIT]   = erase_err;
    assign fl_value[FL_PROG_BIT]    = prog_err;
    assign fl_value[3:2]            = 2'h0;
    assign fl_value[FL_PROT_BIT]    = prot_err;                    // RQ16
    assign fl_value[FL_ADDR4_BIT]   = 1'b1;

    // link fields are stable once deselect is seen here
    assign frame_done = cs_stable & ~cs_stable_q;
    assign locked     = wdis & ~wp_stable;                         // RQ2
    assign write_ok   = frame_done & ~busy & wel;                  // RQ7
    assign is_wren    = frame_done & ~busy & (frame_bits == CMD_BITS)
                        & (cmd_byte == OP_WRITE_ENABLE);
    assign is_wrdi    = frame_done & ~busy & (frame_bits == CMD_BITS)
                        & (cmd_byte == OP_WRITE_DISABLE);
    assign is_clfl    = frame_done & (frame_bits == CMD_BITS)
                        & (cmd_byte == OP_CLEAR_FLAGS);
    assign is_wrsr    = write_ok & (frame_bits == DATA_BITS)
                        & (cmd_byte == OP_WRITE_STATUS);
    assign is_prog    = write_ok & (frame_bits >= PROG_BITS)
                        & (cmd_byte == OP_PROGRAM);
    assign erase_cmd  = (cmd_byte == OP_SECTOR_ERASE) ||
                        (cmd_byte == OP_SUB4_ERASE) ||
                        (cmd_byte == OP_SUB32_ERASE);
    assign is_erase   = write_ok & (frame_bits == ADDR_BITS) & erase_cmd;
    assign is_bulk    = write_ok & (frame_bits == CMD_BITS)
                        & (cmd_byte == OP_BULK_ERASE);

    assign protected_hit = prot.in_range;                          // RQ6
    assign bulk_refused  = (level != LEVEL_NONE);                  // RQ9
    assign refuse        = ((is_prog | is_erase) & protected_hit) |
                           (is_bulk & bulk_refused);               // RQ16
    assign any_err_cmd   = is_prog | is_erase | is_bulk;
    assign start         = (any_err_cmd & ~refuse) |
                           (is_wrsr & ~locked);                    // RQ8

    assign next_op  = is_prog  ? ARR_PROGRAM :
                      is_bulk  ? ARR_ERASE_BULK :
                      (cmd_byte == OP_SECTOR_ERASE) ? ARR_ERASE_SECTOR
                                                    : ARR_ERASE_SUB;
    assign next_tmr = is_wrsr ? TMR_W'(WRSR_CYC) :
                      is_prog ? TMR_W'(PROG_CYC) :
                      is_bulk ? TMR_W'(BULK_CYC) : TMR_W'(ERASE_CYC);

    // nonvolatile status bits
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdis   <= SR_RESET[SR_WDIS_BIT];
            bottom <= SR_RESET[SR_TB_BIT];
            level  <= {SR_RESET[SR_LVL3_BIT],
                       SR_RESET[SR_LVL_HI:SR_LVL_LO]};
        end else if (is_wrsr && !locked) begin                     // RQ18
            wdis   <= data_byte[SR_WDIS_BIT];                      // RQ4
            bottom <= data_byte[SR_TB_BIT];                        // RQ5
            level  <= {data_byte[SR_LVL3_BIT],
                       data_byte[SR_LVL_HI:SR_LVL_LO]};            // RQ6
        end
    end

    // write-enable latch and busy timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wel      <= SR_RESET[SR_WEL_BIT];                      // RQ7
            busy     <= SR_RESET[SR_BUSY_BIT];
            busy_tmr <= '0;
        end else if (busy) begin
            busy_tmr <= busy_tmr - TMR_W'(1);
            if (busy_tmr == TMR_W'(1)) begin
                busy <= 1'b0;                                      // RQ8
                wel  <= 1'b0;
            end
        end else if (start) begin
            busy     <= 1'b1;                                      // RQ8
            busy_tmr <= next_tmr;
        end else if (is_wren) begin
            wel <= 1'b1;                                           // RQ7
        end else if (is_wrdi || refuse) begin
            wel <= 1'b0;
        end
    end

    // error flags: a new error wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prot_err  <= 1'b0;
            prog_err  <= 1'b0;
            erase_err <= 1'b0;
        end else begin
            prot_err  <= refuse | (prot_err & ~is_clfl);           // RQ16
            prog_err  <= (refuse & is_prog) | (prog_err & ~is_clfl);
            erase_err <= (refuse & ~is_prog) | (erase_err & ~is_clfl);
        end
    end

    // array command, only for unprotected targets
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            array_strobe <= 1'b0;
            array_op     <= ARR_PROGRAM;
            array_addr   <= '0;
        end else begin
            array_strobe <= start & any_err_cmd;                   // RQ16
            if (start && any_err_cmd) begin
                array_op   <= next_op;
                array_addr <= addr_word[ADDR_W-1:0];               // RQ15
            end
        end
    end

    // register view and snapshots handed to the link between frames
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_protect_register <= SR_RESET;
            status_snap             <= SR_RESET;
            flag_snap               <= SR_RESET;
        end else begin
            status_protect_register <= sr_value;                   // RQ1
            if (cs_stable) begin
                status_snap <= sr_value;
                flag_snap   <= fl_value;                           // RQ10
            end
        end
    end

endmodule // flash_status_block_protect
`default_nettype wire

// >>> src/protect_range_decode.sv
`timescale 1ns/100ps
`default_nettype none
module protect_range_decode #(
    parameter int SECTOR_W = 9,
    parameter int LEVEL_W  = 4
) (
    protect_range_if.decoder prot
);
    import flash_protect_pkg::*;

    localparam logic [SECTOR_W:0] ONE   = (SECTOR_W+1)'(1);
    localparam logic [SECTOR_W:0] COUNT = ONE << SECTOR_W;

    if (SECTOR_W < int'(LEVEL_FULL) - 1 || LEVEL_W != 4) begin : g_check
        $error("protect_range_decode: sector width too small");
    end

    wire                lvl_zero;
    wire                lvl_full;
    wire [LEVEL_W-1:0]  shift_by;
    wire [SECTOR_W:0]   span;
    wire [SECTOR_W:0]   sector_x;
    wire                top_hit;
    wire                bot_hit;

    // span is 2^(level-1) sectors for levels 1..9
    assign lvl_zero = (prot.level == LEVEL_NONE);                  // RQ11
    assign lvl_full = (prot.level >= LEVEL_FULL);                  // RQ14
    assign shift_by = prot.level - LEVEL_W'(1);
    assign span     = ONE << shift_by;
    assign sector_x = {1'b0, prot.sector};
    assign top_hit  = (sector_x >= (COUNT - span));                // RQ12
    assign bot_hit  = (sector_x < span);                           // RQ13

    assign prot.in_range = lvl_zero ? 1'b0 :                       // RQ6
                           lvl_full ? 1'b1 :
                           prot.bottom ? bot_hit : top_hit;        // RQ5

endmodule // protect_range_decode
`default_nettype wire

// >>> src/protect_range_if.sv
`timescale 1ns/100ps
`default_nettype none
interface protect_range_if #(
    parameter int SECTOR_W = 9,
    parameter int LEVEL_W  = 4
);
    logic [LEVEL_W-1:0]  level;
    logic                bottom;
    logic [SECTOR_W-1:0] sector;
    logic                in_range;

    modport decoder (input level, input bottom, input sector,
                     output in_range);
    modport user    (output level, output bottom, output sector,
                     input in_range);
endinterface
`default_nettype wire

// >>> testbench/flash_status_block_protect_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_block_protect_assertions (
    input wire logic                             mclk,
    input wire logic                             sys_rst,
    input wire logic                             link_cs_n,
    input wire logic                             wp_n,
    input wire logic                             link_miso_oe,
    input wire logic [flash_protect_pkg::SR_WIDTH-1:0]
                                                 status_protect_register,
    input wire logic                             array_strobe,
    input wire flash_protect_pkg::array_op_t     array_op,
    input wire logic [flash_protect_pkg::ADDR_W-1:0] array_addr
);
    import flash_protect_pkg::*;
    wire [7:0] sr = status_protect_register;

    // sector guarded by the current protect level and anchoring
    function automatic logic prot_hit(input logic [7:0] s,
                                      input logic [9:0] sec);
        logic [3:0] n;
        n = {s[6], s[4:2]};
        if (n == 4'h0) return 1'b0;
        if (n >= 4'ha) return 1'b1;
        if (s[5]) return sec < (10'h001 << (n - 1));
        return sec >= 10'h200 - (10'h001 << (n - 1));
    endfunction

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_locked;
        (sr[7] && !wp_n) ##1 !wp_n [*4];
    endsequence
    sequence s_start;
        $rose(array_strobe);
    endsequence

    a_reset_clear: assert property (
        disable iff (1'b0) sys_rst |=> sr == 8'h00 && !array_strobe)
        else $error("status not cleared by reset");
    a_strobe_pulse: assert property (array_strobe |=> !array_strobe)
        else $error("operation strobe longer than one cycle");
    a_strobe_wel: assert property (
        s_start |-> $past(sr[1]) && !$past(sr[0]))
        else $error("operation started without latch or while busy");
    a_busy_follows: assert property (s_start |-> ##[0:2] sr[0])
        else $error("busy not raised by operation");
    a_range_free: assert property (
        array_strobe |-> !prot_hit(sr, {1'b0, array_addr[24:16]}))
        else $error("operation started in guarded sector");
    a_bulk_level: assert property (
        array_strobe && array_op == ARR_ERASE_BULK
            |-> {sr[6], sr[4:2]} == LEVEL_NONE)
        else $error("whole erase with nonzero level");
    a_lock_holds: assert property (s_locked |-> $stable(sr[7:2]))
        else $error("locked status bits changed");
    a_busy_end_wel: assert property ($fell(sr[0]) |-> ##[0:1] !sr[1])
        else $error("latch kept after busy ended");
    a_oe_frame: assert property (link_cs_n |-> !link_miso_oe)
        else $error("serial output driven outside frame");
endmodule // flash_status_block_protect_assertions

bind flash_status_block_protect flash_status_block_protect_assertions
    u_flash_status_block_protect_assertions (
    .mclk(mclk), .sys_rst(sys_rst), .link_cs_n(link_cs_n), .wp_n(wp_n),
    .link_miso_oe(link_miso_oe),
    .status_protect_register(status_protect_register),
    .array_strobe(array_strobe), .array_op(array_op),
    .array_addr(array_addr));
`default_nettype wire

// >>> testbench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output var  logic link_sclk,
    output var  logic link_cs_n,
    output var  logic link_mosi,
    input  wire logic link_miso,
    input  wire logic link_miso_oe
);
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b0;
        link_mosi = 1'b0;
        // a defined rising select clears the link logic at start
        #1 link_cs_n = 1'b1;
    end
    // one frame, msb first from the top; clock stands still outside frames
    task automatic frame(input logic [47:0] frame_bits, input int nbits,
                         output logic [7:0] rd);
        rd = 8'h00;
        #301.7;
        link_cs_n = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            link_mosi = frame_bits[47-i];
            #16 link_sclk = 1'b1;
            rd = {rd[6:0], link_miso_oe ? link_miso : 1'bx};
            #16 link_sclk = 1'b0;
        end
        #16 link_cs_n = 1'b1;
        link_mosi = ~link_mosi;
    endtask
endmodule // spi_host_model
`default_nettype wire

// >>> testbench/tb_flash_status_block_protect.sv
`timescale 1ns/100ps
`default_nettype none
module tb_flash_status_block_protect;
    import flash_protect_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wp_n = 1'b1;
    logic        link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe;
    logic [7:0]  status_protect_register;
    logic        array_strobe;
    array_op_t   array_op;
    logic [24:0] array_addr;
    logic [24:0] last_addr;
    array_op_t   last_op;
    logic [7:0]  rd;
    int          n_errors = 0, num_checks = 0, n_strobe = 0, cycles = 0;

    always #20 mclk = ~mclk;

    flash_status_block_protect #(.WRSR_TIME_NS(200), .PROG_TIME_NS(4000),
        .ERASE_TIME_NS(4000), .BULK_TIME_NS(4000))
        u_flash_status_block_protect (.mclk(mclk), .sys_rst(sys_rst),
        .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
        .wp_n(wp_n), .link_miso(link_miso), .link_miso_oe(link_miso_oe),
        .status_protect_register(status_protect_register),
        .array_strobe(array_strobe), .array_op(array_op),
        .array_addr(array_addr));
    spi_host_model u_spi_host_model (.link_sclk(link_sclk),
        .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
        .link_miso_oe(link_miso_oe));

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (array_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
            last_addr <= array_addr;
            last_op <= array_op;
        end
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [47:0] b, input int n);
        u_spi_host_model.frame(b, n, rd);
    endtask
    task automatic wait_idle();
        repeat (8) @(negedge mclk);
        for (int i = 0; i < 200 && status_protect_register[0] !== 1'b0; i++)
            @(negedge mclk);
        chk(status_protect_register[0], 0);
    endtask
    task automatic write_status(input logic [7:0] d);
        send({OP_WRITE_ENABLE, 40'h0}, 8);
        send({OP_WRITE_STATUS, d, 32'h0}, 16);
        wait_idle();
    endtask
    task automatic try_op(input logic [47:0] b, input int n, input logic prot,
                          input logic [7:0] err, input array_op_t op);
        int s0;
        s0 = n_strobe;
        send({OP_WRITE_ENABLE, 40'h0}, 8);
        send(b, n);
        repeat (12) @(negedge mclk);
        send({OP_READ_FLAGS, 40'h0}, 16);
        if (prot) begin
            chk(n_strobe - s0, 0);
            chk(rd, err);
            chk(status_protect_register[1], 0);
            send({OP_CLEAR_FLAGS, 40'h0}, 8);
        end else begin
            chk(n_strobe - s0, 1);
            chk(last_op, op);
            if (op != ARR_ERASE_BULK) chk(last_addr, b[32:8]);
            chk(rd, 8'h01);
            chk(status_protect_register[0], 1);
            wait_idle();
        end
    endtask

    initial begin
        logic [7:0] d;
        int in_s, out_s;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk(status_protect_register, SR_RESET);
        send({OP_READ_STATUS, 40'h0}, 16);
        chk(rd, 8'h00);
        send({OP_WRITE_STATUS, 8'h24, 32'h0}, 16);
        repeat (12) @(negedge mclk);
        chk(status_protect_register, 8'h00);
        for (int bot = 0; bot < 2; bot++) begin
            for (int n = 0; n < 16; n++) begin
                d = {1'b0, n[3], bot[0], n[2:0], 2'b00};
                write_status(d);
                chk(status_protect_register, d);
                send({OP_READ_STATUS, 40'h0}, 16);
                chk(rd, d);
                if (n == 0 || n >= 10) begin
                    in_s = bot ? 0 : 511;
                    out_s = bot ? 511 : 0;
                end else begin
                    in_s = bot ? (1 << (n - 1)) - 1 : 512 - (1 << (n - 1));
                    out_s = bot ? in_s + 1 : in_s - 1;
                end
                try_op({OP_PROGRAM, 7'h00, in_s[8:0], 16'h0100, 8'h5a}, 48,
                       n != 0, 8'h93, ARR_PROGRAM);
                try_op({OP_PROGRAM, 7'h00, out_s[8:0], 16'h0100, 8'h5a}, 48,
                       n >= 10, 8'h93, ARR_PROGRAM);
            end
        end
        try_op({OP_BULK_ERASE, 40'h0}, 8, 1'b1, 8'ha3, ARR_ERASE_BULK);
        write_status(8'h80);
        chk(status_protect_register, 8'h80);
        try_op({OP_BULK_ERASE, 40'h0}, 8, 1'b0, 8'h00, ARR_ERASE_BULK);
        try_op({OP_SECTOR_ERASE, 32'h01ff0000, 8'h00}, 40, 1'b0, 8'h00,
               ARR_ERASE_SECTOR);
        send({OP_WRITE_ENABLE, 40'h0}, 8);
        repeat (8) @(negedge mclk);
        chk(status_protect_register[1], 1);
        send({OP_WRITE_DISABLE, 40'h0}, 8);
        repeat (8) @(negedge mclk);
        chk(status_protect_register[1], 0);
        wp_n = 1'b0;
        write_status(8'h24);
        chk(status_protect_register, 8'h82);
        wp_n = 1'b1;
        write_status(8'h24);
        chk(status_protect_register, 8'h24);
        try_op({OP_SUB4_ERASE, 32'h00000000, 8'h00}, 40, 1'b1, 8'ha3,
               ARR_ERASE_SUB);
        try_op({OP_SUB32_ERASE, 32'h00018000, 8'h00}, 40, 1'b0, 8'h00,
               ARR_ERASE_SUB);
        stop_test();
    end
endmodule // tb_flash_status_block_protect
`default_nettype wire
